// [rtl/scct_pkg.sv]
// Package of register map, field layouts and encodings for the capture/compare timer
package scct_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses (one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;  // Control, timer_system_control_one
    localparam logic [7:0] A_DIR = 8'h04;   // channel_direction_select
    localparam logic [7:0] A_CFG = 8'h08;   // Per-channel edge and action
    localparam logic [7:0] A_CNT = 8'h0c;   // Free-running counter
    localparam logic [7:0] A_STAT = 8'h10;  // Sticky events, cleared by read
    localparam logic [7:0] A_MASK = 8'h14;  // Interrupt mask
    localparam logic [7:0] A_PACNT = 8'h18; // Pulse accumulator count
    localparam logic [2:0] A_CHAN_HI = 3'h1; // Channel words at 0x20 + 4*n
    localparam logic [1:0] A_LANE0 = 2'h0;  // Aligned word only

    // ----------------------------------------------------------------
    // Widths and status bit positions
    // ----------------------------------------------------------------
    localparam int CW = 16;        // Counter width
    localparam int MAX_CH = 8;     // Most channels the map can hold
    localparam int PA_CH = 7;      // Channel that feeds the accumulator
    localparam int ST_OVF = 8;     // Counter overflow
    localparam int ST_PAOVF = 9;   // Accumulator overflow
    localparam int ST_PAEDG = 10;  // Accumulator input edge
    localparam int ST_W = 11;      // Status width
    localparam int PRE_W = 7;      // Prescale counter width
    localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
    localparam logic [CW-1:0] CNT_MAX = 16'hffff;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;

    // ----------------------------------------------------------------
    // Control register layout, reset value all zero (timer stopped)
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pa_edge;           // Accumulator edge / active level
        logic pa_gated;          // 1 = gated time, 0 = event count
        logic pa_en;             // Accumulator enable
        logic rsv1;              // Reads zero
        logic [2:0] prescale;    // Divide by 2**prescale
        logic rsv0;              // Reads zero
        logic freeze_halt;       // Halt in freeze mode
        logic wait_halt;         // Halt in wait mode
        logic timer_enable_bit;  // Counter runs when set
    } scct_ctrl_t;
    localparam int CTRL_W = 11;

    // Capture edge selection
    localparam logic [1:0] EDG_OFF = 2'h0;
    localparam logic [1:0] EDG_RISE = 2'h1;
    localparam logic [1:0] EDG_FALL = 2'h2;
    localparam logic [1:0] EDG_BOTH = 2'h3;
    // Compare pin action
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // Per-channel configuration nibble
    typedef struct packed {
        logic [1:0] edge_sel;  // Capture edge
        logic [1:0] action;    // Compare pin action
    } scct_chcfg_t;
    localparam int CHCFG_W = 4;
endpackage : scct_pkg

// [rtl/scct_channel.sv]
// One capture/compare channel: edge capture, compare match, pin action
module scct_channel
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic tick,
    input wire logic [scct_pkg::CW-1:0] cnt,
    input wire logic is_cmp,
    input wire scct_pkg::scct_chcfg_t cfg,
    input wire logic pin_in,
    input wire logic wr,
    input wire logic [scct_pkg::CW-1:0] wdata,
    output logic [scct_pkg::CW-1:0] val,
    output logic evt,
    output logic pin_out
);
    logic pin_prev_q;                   // Last pin sample, for edges
    logic [scct_pkg::CW-1:0] val_q;     // Capture or compare value
    logic out_q;                        // Compare pin level

    // ----------------------------------------------------------------
    // Edge and match decode
    // ----------------------------------------------------------------
    wire rise = pin_in & ~pin_prev_q;
    wire fall = ~pin_in & pin_prev_q;
    wire hit_edge = ((cfg.edge_sel == scct_pkg::EDG_RISE) & rise)
                  | ((cfg.edge_sel == scct_pkg::EDG_FALL) & fall)
                  | ((cfg.edge_sel == scct_pkg::EDG_BOTH) & (rise | fall));
    wire cap = active & ~is_cmp & hit_edge;
    wire match = active & is_cmp & tick & (cnt == val_q);
    assign evt = cap | match;
    assign val = val_q;
    assign pin_out = out_q;

    // ----------------------------------------------------------------
    // Registers; a bus write beats a capture in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_prev_q <= 1'b0;
            val_q <= '0;
            out_q <= 1'b0;
        end
        else
        begin
            pin_prev_q <= pin_in;
            if (wr)
                val_q <= wdata;
            else if (cap)
                val_q <= cnt;
            // Action on match; none leaves a pure software delay event
            if (match)
            begin
                case (cfg.action)
                    scct_pkg::ACT_TOGGLE: out_q <= ~out_q;
                    scct_pkg::ACT_CLEAR: out_q <= 1'b0;
                    scct_pkg::ACT_SET: out_q <= 1'b1;
                    default: out_q <= out_q;
                endcase
            end
        end
    end

    AST_CAPTURE_TIME: assert property (@(posedge clk) disable iff (!rstn)
        (cap && !wr) |=> (val_q == $past(cnt)))
        else $error("capture did not record counter");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
        (match && cfg.action == scct_pkg::ACT_TOGGLE) |=> (out_q != $past(out_q)))
        else $error("compare toggle missed");
endmodule : scct_channel

// [rtl/scct_pacc.sv]
// Pulse accumulator: event counter or gated time accumulator
module scct_pacc
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic en,
    input wire logic gated,
    input wire logic edge_pol,
    input wire logic tick,
    input wire logic pin,
    input wire logic wr,
    input wire logic [scct_pkg::CW-1:0] wdata,
    output logic [scct_pkg::CW-1:0] count,
    output logic ovf,
    output logic edg
);
    logic pin_prev_q;                  // Previous pin sample
    logic [scct_pkg::CW-1:0] cnt_q;    // Accumulated count

    // ----------------------------------------------------------------
    // Increment sources
    // ----------------------------------------------------------------
    // Event mode counts the edge chosen by edge_pol (1 rising, 0 falling);
    // gated mode counts prescaled ticks while pin equals edge_pol
    wire sel_edge = (pin != pin_prev_q) & (pin == edge_pol);
    wire end_gate = (pin != pin_prev_q) & (pin_prev_q == edge_pol);
    wire inc = active & en & (gated ? (tick & (pin == edge_pol)) : sel_edge);
    assign ovf = inc & (cnt_q == scct_pkg::CNT_MAX);
    assign edg = active & en & (gated ? end_gate : sel_edge);
    assign count = cnt_q;

    // ----------------------------------------------------------------
    // Counter; a bus write takes priority over counting
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_prev_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            pin_prev_q <= pin;
            if (wr)
                cnt_q <= wdata;
            else if (inc)
                cnt_q <= cnt_q + scct_pkg::CNT_ONE;
        end
    end

    AST_PA_EVENT: assert property (@(posedge clk) disable iff (!rstn)
        (inc && !wr) |=> (cnt_q == $past(cnt_q) + scct_pkg::CNT_ONE))
        else $error("accumulator missed a count");
    AST_PA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
        (!en && !wr) |=> $stable(cnt_q))
        else $error("accumulator counted while disabled");
    COV_PA_OVF: cover property (@(posedge clk) disable iff (!rstn) ovf);
endmodule : scct_pacc

// [rtl/scct_timer.sv]
// Top of the capture/compare timer: APB registers, prescaler, counter, channels
module scct_timer #(
    parameter int NCH = 8  // Implemented channels
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    input wire logic freeze_mode,
    input wire logic wait_mode,
    input wire logic [NCH-1:0] chan_in,
    output logic [NCH-1:0] chan_out,
    output logic [NCH-1:0] chan_oe,
    output logic irq
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (NCH < 1 || NCH > scct_pkg::MAX_CH)
    begin : g_bad_nch
        $error("NCH must be 1 to 8");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Writable control bits; the two reserved positions always read zero
    localparam scct_pkg::scct_ctrl_t CTRL_WMASK = '{
        pa_edge: 1'b1,
        pa_gated: 1'b1,
        pa_en: 1'b1,
        rsv1: 1'b0,
        prescale: 3'h7,
        rsv0: 1'b0,
        freeze_halt: 1'b1,
        wait_halt: 1'b1,
        timer_enable_bit: 1'b1
    };

    scct_pkg::scct_ctrl_t ctrl_q;              // Control word
    logic [NCH-1:0] dir_q;                     // 1 = compare
    logic [NCH*scct_pkg::CHCFG_W-1:0] cfg_q;   // Channel configs
    logic [scct_pkg::CW-1:0] cnt_q;            // Main counter
    logic [scct_pkg::PRE_W-1:0] pre_q;         // Prescale counter
    logic [scct_pkg::ST_W-1:0] stat_q;         // Sticky events
    logic [scct_pkg::ST_W-1:0] stat_d;
    logic [scct_pkg::ST_W-1:0] mask_q;         // Interrupt mask
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic [NCH-1:0] oe_q;

    logic [scct_pkg::CW-1:0] ch_val [NCH];     // Channel values
    logic [NCH-1:0] ch_evt;                    // Channel events
    logic [scct_pkg::CW-1:0] pa_cnt;
    logic pa_ovf;
    logic pa_edg;

    // ----------------------------------------------------------------
    // APB decode: one wait state, request completes when pready_q is high
    // ----------------------------------------------------------------
    wire req = psel & penable;
    wire first = req & ~pready_q;
    wire done = req & pready_q;
    wire wr = done & pwrite;
    wire rd = done & ~pwrite;
    wire [2:0] chan_idx = paddr[4:2];
    wire hit_ctrl = (paddr == scct_pkg::A_CTRL);
    wire hit_dir = (paddr == scct_pkg::A_DIR);
    wire hit_cfg = (paddr == scct_pkg::A_CFG);
    wire hit_cnt = (paddr == scct_pkg::A_CNT);
    wire hit_stat = (paddr == scct_pkg::A_STAT);
    wire hit_mask = (paddr == scct_pkg::A_MASK);
    wire hit_pacnt = (paddr == scct_pkg::A_PACNT);
    wire hit_chan = (paddr[7:5] == scct_pkg::A_CHAN_HI) & (paddr[1:0] == scct_pkg::A_LANE0)
                  & (int'(chan_idx) < NCH);
    wire mapped = hit_ctrl | hit_dir | hit_cfg | hit_cnt | hit_stat | hit_mask
                | hit_pacnt | hit_chan;
    wire wr_cnt = wr & hit_cnt;
    // Full 32-bit words only, so a counter read is always coherent
    wire [31:0] rdmux =
        hit_ctrl ? 32'(ctrl_q) :
        hit_dir ? 32'(dir_q) :
        hit_cfg ? 32'(cfg_q) :
        hit_cnt ? 32'(cnt_q) :
        hit_stat ? 32'(stat_q) :
        hit_mask ? 32'(mask_q) :
        hit_pacnt ? 32'(pa_cnt) :
        hit_chan ? 32'(ch_val[chan_idx]) : '0;

    // ----------------------------------------------------------------
    // Run gating and prescaler
    // ----------------------------------------------------------------
    wire active = ~stop_mode;
    wire run = ctrl_q.timer_enable_bit & active
             & ~(freeze_mode & ctrl_q.freeze_halt)
             & ~(wait_mode & ctrl_q.wait_halt);
    // Limit wraps to all ones for prescale 7, giving divide by 128
    wire [scct_pkg::PRE_W-1:0] pre_lim = (scct_pkg::PRE_ONE << ctrl_q.prescale)
                                       - scct_pkg::PRE_ONE;
    // Greater-or-equal, not equal: when software lowers the divider while the
    // prescaler stands above the new limit, the next cycle ticks at once instead
    // of running the prescaler round its whole range first
    wire tick = run & (pre_q >= pre_lim);
    wire ovf = tick & (cnt_q == scct_pkg::CNT_MAX);

    // Prescaler restarts on each tick; held while not running
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pre_q <= '0;
        else if (tick)
            pre_q <= '0;
        else if (run)
            pre_q <= pre_q + scct_pkg::PRE_ONE;
    end

    // Counter: software write wins over a tick in the same cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= '0;
        else if (wr_cnt)
            cnt_q <= pwdata[scct_pkg::CW-1:0];
        else if (tick)
            cnt_q <= cnt_q + scct_pkg::CNT_ONE;
    end

    // ----------------------------------------------------------------
    // Channels, all identical
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        scct_channel u_ch (
            .clk(clk),
            .rstn(rstn),
            .active(active),
            .tick(tick),
            .cnt(cnt_q),
            .is_cmp(dir_q[g]),
            .cfg(cfg_q[g*scct_pkg::CHCFG_W +: scct_pkg::CHCFG_W]),
            .pin_in(chan_in[g]),
            .wr(wr & hit_chan & (int'(chan_idx) == g)),
            .wdata(pwdata[scct_pkg::CW-1:0]),
            .val(ch_val[g]),
            .evt(ch_evt[g]),
            .pin_out(chan_out[g])
        );
    end

    // ----------------------------------------------------------------
    // Pulse accumulator on the channel 7 pin, only when it exists
    // ----------------------------------------------------------------
    wire pa_pin;
    if (NCH > scct_pkg::PA_CH)
    begin : g_pa_pin
        assign pa_pin = chan_in[scct_pkg::PA_CH];
    end
    else
    begin : g_pa_none
        assign pa_pin = 1'b0;
    end

    scct_pacc u_pa (
        .clk(clk),
        .rstn(rstn),
        .active(active),
        .en(ctrl_q.pa_en & (NCH > scct_pkg::PA_CH)),
        .gated(ctrl_q.pa_gated),
        .edge_pol(ctrl_q.pa_edge),
        .tick(tick),
        .pin(pa_pin),
        .wr(wr & hit_pacnt),
        .wdata(pwdata[scct_pkg::CW-1:0]),
        .count(pa_cnt),
        .ovf(pa_ovf),
        .edg(pa_edg)
    );

    // ----------------------------------------------------------------
    // Sticky status: a read clears, but a new event in that cycle wins
    // ----------------------------------------------------------------
    wire [scct_pkg::ST_W-1:0] events = {pa_edg, pa_ovf, ovf, 8'(ch_evt)};
    // Read data are latched one cycle before the clear, so only the bits that
    // software was shown are cleared; an event landing in between survives
    wire [scct_pkg::ST_W-1:0] rd_seen = prdata_q[scct_pkg::ST_W-1:0];
    assign stat_d = ((rd & hit_stat) ? (stat_q & ~rd_seen) : stat_q) | events;

    // Software registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= '0;
            dir_q <= '0;
            cfg_q <= '0;
            mask_q <= '0;
        end
        else if (wr)
        begin
            // Reserved control bits stay zero
            if (hit_ctrl)
                ctrl_q <= scct_pkg::scct_ctrl_t'(pwdata[scct_pkg::CTRL_W-1:0] & CTRL_WMASK);
            if (hit_dir)
                dir_q <= pwdata[NCH-1:0];
            if (hit_cfg)
                cfg_q <= pwdata[NCH*scct_pkg::CHCFG_W-1:0];
            if (hit_mask)
                mask_q <= pwdata[scct_pkg::ST_W-1:0];
        end
    end

    // Status, interrupt, pin enables and bus answer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_q <= '0;
            irq_q <= 1'b0;
            oe_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            stat_q <= stat_d;
            irq_q <= |(stat_q & mask_q);
            oe_q <= dir_q;
            pready_q <= first;
            pslverr_q <= first & ~mapped;
            // Unmapped reads answer zero
            if (first & ~pwrite)
                prdata_q <= rdmux;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign chan_oe = oe_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_CNT_STEP: assert property (@(posedge clk) disable iff (!rstn)
        (tick && !wr_cnt && !ovf) |=> (cnt_q == $past(cnt_q) + scct_pkg::CNT_ONE))
        else $error("counter did not advance on tick");
    AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!rstn)
        (stop_mode && !wr_cnt) |=> $stable(cnt_q) && $stable(pre_q))
        else $error("counter moved in stop mode");
    AST_FREEZE_HALT: assert property (@(posedge clk) disable iff (!rstn)
        (freeze_mode && ctrl_q.freeze_halt && !wr_cnt) |=> $stable(cnt_q))
        else $error("counter moved while frozen");
    AST_WAIT_HALT: assert property (@(posedge clk) disable iff (!rstn)
        (wait_mode && ctrl_q.wait_halt && !wr_cnt) |=> $stable(cnt_q))
        else $error("counter moved in wait");
    AST_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
        (!ctrl_q.timer_enable_bit && !wr_cnt) |=> $stable(cnt_q))
        else $error("counter moved while disabled");
    AST_WRAP: assert property (@(posedge clk) disable iff (!rstn)
        (ovf && !wr_cnt) |=> (cnt_q == '0) && stat_q[scct_pkg::ST_OVF])
        else $error("overflow wrap or flag missing");
    AST_CH_FLAG: assert property (@(posedge clk) disable iff (!rstn)
        ch_evt[0] |=> stat_q[0] ##1 (irq || !$past(mask_q[0])))
        else $error("channel flag or interrupt missing");
    AST_OE_DIR: assert property (@(posedge clk) disable iff (!rstn)
        $changed(dir_q) |=> (chan_oe == $past(dir_q)))
        else $error("pin enable not following direction");
    AST_APB_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        first |=> pready_q ##1 !pready_q)
        else $error("bus answer timing wrong");
    AST_RD_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        (rd && hit_stat && events == '0) |=> ((stat_q & $past(rd_seen)) == '0))
        else $error("status read did not clear reported bits");

    COV_OVF: cover property (@(posedge clk) disable iff (!rstn) ovf);
    COV_CAPTURE: cover property (@(posedge clk) disable iff (!rstn) ch_evt[0] && !dir_q[0]);
    COV_COMPARE: cover property (@(posedge clk) disable iff (!rstn) ch_evt[0] && dir_q[0]);
endmodule : scct_timer

// [tb/scct_pins.sv]
// Pin-side model: drives capture inputs and loops compare outputs back
module scct_pins
(
    input wire logic clk,
    input wire logic [7:0] drv,
    input wire logic [7:0] chan_out,
    input wire logic [7:0] chan_oe,
    output logic [7:0] chan_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven pins show the design's level; the rest follow the bench
    always_ff @(posedge clk)
        chan_in <= (chan_oe & chan_out) | (~chan_oe & drv);
endmodule : scct_pins

// [tb/scct_timer_tb.sv]
// Self-checking bench of the capture/compare timer
module scct_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic stop_mode, freeze_mode, wait_mode;
    logic [7:0] paddr, drv, chan_in, chan_out, chan_oe;
    logic [31:0] pwdata, prdata, rd, c0;
    int bad_count, n_tests;
    // ------------------------------------------------------------
    // Design and pin model
    // ------------------------------------------------------------
    scct_timer #(.NCH(8)) i_scct_timer (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .freeze_mode(freeze_mode), .wait_mode(wait_mode), .chan_in(chan_in),
        .chan_out(chan_out), .chan_oe(chan_oe), .irq(irq));
    scct_pins i_scct_pins (.clk(clk), .drv(drv), .chan_out(chan_out), .chan_oe(chan_oe),
        .chan_in(chan_in));
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Whole-word APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A missing answer ends the run as a failure
        if (k == 16)
        begin
            bad_count++;
            end_sim();
        end
    endtask : apb
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, writable bits, unmapped and misaligned refusals
    task automatic t_regs();
        apb(0, scct_pkg::A_CTRL, 0);
        chk(rd, 32'h0);
        apb(1, scct_pkg::A_CTRL, 32'hffffffff);
        apb(0, scct_pkg::A_CTRL, 0);
        chk(rd, 32'h777);
        apb(1, scct_pkg::A_CTRL, 0);
        apb(0, 8'h1c, 0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(0, 8'h0d, 0);
        chk({31'h0, er}, 32'h1);
    endtask : t_regs
    // Wrap sets the sticky overflow; read clears it, irq follows the mask
    task automatic t_wrap();
        apb(1, scct_pkg::A_MASK, 32'h100);
        apb(1, scct_pkg::A_CNT, 32'hfffe);
        apb(1, scct_pkg::A_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(0, scct_pkg::A_STAT, 0);
        chk(rd, 32'h100);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(0, scct_pkg::A_STAT, 0);
        chk(rd, 32'h0);
    endtask : t_wrap
    // Divide by four: about a quarter of the elapsed cycles
    task automatic t_pre();
        apb(1, scct_pkg::A_CTRL, 32'h21);
        apb(1, scct_pkg::A_CNT, 32'h0);
        repeat (80) @(posedge clk);
        apb(0, scct_pkg::A_CNT, 0);
        chk({31'h0, rd >= 19 && rd <= 22}, 32'h1);
    endtask : t_pre
    // Halting table: control word, mode pins {stop, freeze, wait}, expect held
    task automatic t_halt();
        logic [31:0] cw [5] = '{32'h1, 32'h5, 32'h3, 32'h0, 32'h3};
        logic [2:0] md [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h2};
        logic hold [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            {stop_mode, freeze_mode, wait_mode} <= md[i];
            apb(1, scct_pkg::A_CTRL, cw[i]);
            apb(0, scct_pkg::A_CNT, 0);
            c0 = rd;
            repeat (10) @(posedge clk);
            apb(0, scct_pkg::A_CNT, 0);
            chk({31'h0, rd === c0}, {31'h0, hold[i]});
        end
        @(posedge clk);
        {stop_mode, freeze_mode, wait_mode} <= 3'h0;
    endtask : t_halt
    // Rising edge on every capture channel records the counter time
    task automatic t_cap();
        apb(1, scct_pkg::A_CTRL, 32'h71);
        apb(1, scct_pkg::A_DIR, 32'h0);
        apb(1, scct_pkg::A_CFG, 32'h44444444);
        apb(1, scct_pkg::A_CNT, 32'h1234);
        apb(1, scct_pkg::A_MASK, 32'hff);
        @(posedge clk);
        drv <= 8'hff;
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        for (int n = 0; n < 8; n++)
        begin
            apb(0, 8'h20 + 8'(4 * n), 0);
            chk({31'h0, rd == 32'h1234 || rd == 32'h1235}, 32'h1);
        end
        apb(0, scct_pkg::A_STAT, 0);
        chk(rd, 32'hff);
        drv <= 8'h0;
    endtask : t_cap
    // Channel 1 as compare, toggling its pin when the counter passes 0x40
    task automatic t_cmp();
        apb(1, scct_pkg::A_DIR, 32'h2);
        apb(1, scct_pkg::A_CFG, 32'h10);
        apb(1, 8'h24, 32'h40);
        apb(1, scct_pkg::A_CTRL, 32'h1);
        apb(1, scct_pkg::A_CNT, 32'h0);
        repeat (80) @(posedge clk);
        chk({30'h0, chan_oe[1:0], chan_out[1]}, 32'h5);
        apb(0, scct_pkg::A_STAT, 0);
        chk(rd, 32'h2);
    endtask : t_cmp
    // Accumulator counts rising edges on the shared channel 7 pin
    task automatic t_pacc();
        apb(1, scct_pkg::A_DIR, 32'h0);
        apb(1, scct_pkg::A_CTRL, 32'h501);
        apb(1, scct_pkg::A_PACNT, 32'h0);
        repeat (3)
        begin
            @(posedge clk);
            drv <= 8'h80;
            repeat (3) @(posedge clk);
            drv <= 8'h0;
            repeat (2) @(posedge clk);
        end
        apb(0, scct_pkg::A_PACNT, 0);
        chk(rd, 32'h3);
    endtask : t_pacc
    // Falling-edge capture, set action and gated accumulation in one run
    task automatic t_modes();
        apb(1, scct_pkg::A_DIR, 32'h8);
        apb(1, scct_pkg::A_CFG, 32'h3800);
        apb(1, 8'h2c, 32'h20);
        apb(1, scct_pkg::A_CTRL, 32'h701);
        apb(1, scct_pkg::A_PACNT, 32'h0);
        apb(1, scct_pkg::A_CNT, 32'h0);
        drv <= 8'h84;
        repeat (20) @(posedge clk);
        drv <= 8'h0;
        repeat (60) @(posedge clk);
        chk({31'h0, chan_out[3]}, 32'h1);
        apb(0, 8'h28, 0);
        chk(rd, 32'h15);
        apb(0, scct_pkg::A_PACNT, 0);
        chk(rd, 32'h14);
        apb(0, scct_pkg::A_STAT, 0);
        chk(rd, 32'h40c);
    endtask : t_modes
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rstn, psel, penable, pwrite, stop_mode, freeze_mode, wait_mode} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        drv = 8'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_wrap();
        t_pre();
        t_halt();
        t_cap();
        t_cmp();
        t_pacc();
        t_modes();
        end_sim();
    end
endmodule : scct_timer_tb
